// ===== logic/dio_pkg.sv
// Purpose: shared constants and types of the debug i/o block
// Assumes: 25 MHz system clock, APB byte addresses in paddr[7:0]
// Notes:   register map, reset values, field positions, serial timing
package dio_pkg;

  // system clock and serial timing
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned SERIAL_BIT_RATE = 115200;
  localparam int unsigned BIT_CYCLES      = CLK_HZ / SERIAL_BIT_RATE;
  localparam logic [7:0]  BIT_CNT_MAX     = 8'(BIT_CYCLES - 1);
  localparam logic [7:0]  HALF_CNT_MAX    = 8'(BIT_CYCLES / 2 - 1);
  localparam logic [3:0]  FRAME_PERIODS   = 4'd10;
  localparam logic [2:0]  LAST_DATA_BIT   = 3'd7;

  // register byte addresses
  localparam logic [7:0] ADDR_BUTTON    = 8'h00;
  localparam logic [7:0] ADDR_INDICATOR = 8'h04;
  localparam logic [7:0] ADDR_PROBE     = 8'h08;
  localparam logic [7:0] ADDR_SERIAL    = 8'h0c;
  localparam logic [7:0] ADDR_SER_STAT  = 8'h10;
  localparam logic [7:0] ADDR_HANDSHAKE = 8'h14;
  localparam logic [7:0] ADDR_USB_PORT  = 8'h18;
  localparam logic [7:0] ADDR_USB_DIR   = 8'h1c;

  // values after reset
  localparam logic [3:0] IND_RST      = 4'h5;
  localparam logic [7:0] PROBE_RST    = 8'h00;
  localparam logic       CLEAR_RST    = 1'b0;
  localparam logic [7:0] USB_DATA_RST = 8'h55;
  localparam logic [7:0] USB_OE_RST   = 8'hff;
  localparam logic [2:0] USB_STRB_RST = 3'h0;
  localparam logic [2:0] BUTTON_IDLE  = 3'h7;

  // field positions
  localparam int unsigned STAT_RX_VALID = 0;
  localparam int unsigned STAT_TX_FULL  = 1;
  localparam int unsigned STAT_TX_BUSY  = 2;
  localparam int unsigned STAT_OVERRUN  = 3;
  localparam int unsigned STAT_FRAMING  = 4;
  localparam int unsigned HS_CLEAR      = 0;
  localparam int unsigned HS_REQUEST    = 1;
  localparam int unsigned USB_STAT_LSB  = 8;
  localparam int unsigned USB_STRB_LSB  = 12;

  // transmit buffer shape
  localparam int unsigned TX_FIFO_W = 8;
  localparam int unsigned TX_FIFO_D = 4;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } dio_rx_e;

endpackage : dio_pkg

// ===== logic/dio_sync.sv
// Purpose: two-stage synchroniser for a group of pin inputs
// Assumes: inputs are asynchronous to sys_clk_i
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module dio_sync #(
  parameter int unsigned   W   = 1,
  parameter logic [W-1:0]  RST = '0
) (
  input  wire logic         sys_clk_i,
  input  wire logic         arst_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } dio_sync_s;

  dio_sync_s s_q;
  dio_sync_s s_d;

  // shift the pin level through two flops
  always_comb begin
    s_d.meta   = async_i;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q.meta   <= RST;
      s_q.stable <= RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_o = s_q.stable;

endmodule : dio_sync
`default_nettype wire

// ===== logic/dio_fifo.sv
// Purpose: small first-in first-out buffer with valid/ready both sides
// Assumes: one clock, width and depth fixed by the instance
// Notes:   full drops in_ready, empty drops out_valid
`timescale 1ns/1ps
`default_nettype none
module dio_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 4
) (
  input  wire logic         sys_clk_i,
  input  wire logic         arst_n_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic      [W-1:0] out_data_o
);

  localparam int unsigned PW = (D > 1) ? $clog2(D) : 1;
  localparam int unsigned CW = $clog2(D + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(D - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [PW-1:0]       rd;
    logic [PW-1:0]       wr;
    logic [CW-1:0]       cnt;
  } dio_fifo_s;

  dio_fifo_s s_q;
  dio_fifo_s s_d;
  logic      push;
  logic      pop;

  assign in_ready_o  = (s_q.cnt != CNT_FULL);
  assign out_valid_o = (s_q.cnt != '0);
  assign out_data_o  = s_q.mem[s_q.rd];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // pointer and count update
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr] = in_data_i;
      s_d.wr = (s_q.wr == PTR_LAST) ? '0 : s_q.wr + 1'b1;
    end
    if (pop) begin
      s_d.rd = (s_q.rd == PTR_LAST) ? '0 : s_q.rd + 1'b1;
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : dio_fifo
`default_nettype wire

// ===== logic/dio_top.sv
// Purpose: debug i/o block: buttons, indicators, probe, serial, usb port
// Assumes: APB slave, 25 MHz clock, async active-low reset
// Notes:   each access phase takes two cycles, tx writes stall when full
//
// Notes on behaviour
// - three button inputs readable separately; low means pressed, high idle.
// - four indicator outputs, each lit when its bit is written zero.
// - indicators reset to one on bits 0 and 2, zero on 1 and 3.
// - serial runs 115200 baud, 8 data, no parity, 1 stop, no flow.
// - serial receive is an input, serial transmit is an output.
// - bridge request read as one input bit; clear output defaults zero.
// - eight-bit probe data bus driven with its own probe clock.
// - fifteen-bit usb port: 8 data, 4 status inputs, 3 strobe outputs.
// - usb data resets to 0x55; status and strobe bits reset to zero.
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dio_top
  import dio_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic [2:0]  debug_button_in_i,
  output logic      [3:0]  debug_indicator_out_o,
  output logic      [7:0]  probe_data_out_o,
  output logic             probe_clock_out_o,
  input  wire logic        serial_rx_in_i,
  output logic             serial_tx_out_o,
  input  wire logic        bridge_request_in_i,
  output logic             bridge_clear_out_o,
  input  wire logic [7:0]  usb_fifo_data_i,
  output logic      [7:0]  usb_fifo_data_o,
  output logic      [7:0]  usb_fifo_data_oe_o,
  input  wire logic        usb_fifo_tx_space_i,
  input  wire logic        usb_fifo_rx_valid_i,
  input  wire logic        usb_fifo_power_enable_i,
  input  wire logic        usb_fifo_reset_status_i,
  output logic             usb_fifo_read_strobe_o,
  output logic             usb_fifo_write_strobe_o,
  output logic             usb_fifo_send_now_o
);

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  ind;
    logic [7:0]  probe;
    logic        probe_arm;
    logic        probe_clk;
    logic        clear;
    logic [7:0]  usb_out;
    logic [7:0]  usb_oe;
    logic [2:0]  usb_strb;
    logic        tx_line;
    logic [8:0]  tx_shift;
    logic [3:0]  tx_left;
    logic [7:0]  tx_cnt;
    dio_rx_e     rx_state;
    logic [7:0]  rx_cnt;
    logic [2:0]  rx_bit;
    logic [7:0]  rx_shift;
    logic [7:0]  rx_data;
    logic        rx_valid;
    logic        rx_overrun;
    logic        rx_framing;
  } dio_top_s;

  dio_top_s    s_q;
  dio_top_s    s_d;
  logic [2:0]  button_sync;
  logic [1:0]  hs_sync;
  logic [3:0]  usb_stat_sync;
  logic [7:0]  usb_data_sync;
  logic        access;
  logic        wr_tx;
  logic        take;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        fifo_out_ready;
  logic [7:0]  fifo_out_data;
  logic [31:0] rd_val;
  logic        rd_hit;

  // buttons idle high so they reset high
  dio_sync #(
    .W   (3),
    .RST (BUTTON_IDLE)
  ) u_sync_button (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .async_i   (debug_button_in_i),
    .sync_o    (button_sync)
  );

  // serial receive line and bridge request, line idles high
  dio_sync #(
    .W   (2),
    .RST (2'h1)
  ) u_sync_hs (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .async_i   ({bridge_request_in_i, serial_rx_in_i}),
    .sync_o    (hs_sync)
  );

  // usb status bits and data bus inputs
  dio_sync #(
    .W   (12),
    .RST (12'h000)
  ) u_sync_usb (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .async_i   ({usb_fifo_reset_status_i, usb_fifo_power_enable_i,
                 usb_fifo_rx_valid_i, usb_fifo_tx_space_i,
                 usb_fifo_data_i}),
    .sync_o    ({usb_stat_sync, usb_data_sync})
  );

  // transmit bytes queue here until the shifter is free
  dio_fifo #(
    .W (TX_FIFO_W),
    .D (TX_FIFO_D)
  ) u_tx_fifo (
    .sys_clk_i   (sys_clk_i),
    .arst_n_i    (arst_n_i),
    .in_valid_i  (wr_tx),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (pwdata_i[7:0]),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data)
  );

  // first access cycle is taken; a full buffer holds the write off
  assign access         = psel_i & penable_i & ~s_q.pready;
  assign wr_tx          = access & pwrite_i & (paddr_i == ADDR_SERIAL);
  assign take           = access & ~(wr_tx & ~fifo_in_ready);
  assign fifo_out_ready = (s_q.tx_left == '0);

  // read mux over the register map
  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    case (paddr_i)
      ADDR_BUTTON:    rd_val[2:0] = button_sync;
      ADDR_INDICATOR: rd_val[3:0] = s_q.ind;
      ADDR_PROBE:     rd_val[7:0] = s_q.probe;
      ADDR_SERIAL:    rd_val[7:0] = s_q.rx_data;
      ADDR_SER_STAT: begin
        rd_val[STAT_RX_VALID] = s_q.rx_valid;
        rd_val[STAT_TX_FULL]  = ~fifo_in_ready;
        rd_val[STAT_TX_BUSY]  = fifo_out_valid | (s_q.tx_left != '0);
        rd_val[STAT_OVERRUN]  = s_q.rx_overrun;
        rd_val[STAT_FRAMING]  = s_q.rx_framing;
      end
      ADDR_HANDSHAKE: begin
        rd_val[HS_CLEAR]   = s_q.clear;
        rd_val[HS_REQUEST] = hs_sync[1];
      end
      ADDR_USB_PORT: begin
        rd_val[7:0] = usb_data_sync;
        rd_val[USB_STAT_LSB +: 4] = usb_stat_sync;
        rd_val[USB_STRB_LSB +: 3] = s_q.usb_strb;
      end
      ADDR_USB_DIR:   rd_val[7:0] = s_q.usb_oe;
      default:        rd_hit = 1'b0;
    endcase
  end

  // bus side effects first, hardware events after so a set wins
  always_comb begin
    s_d = s_q;
    s_d.pready    = 1'b0;
    s_d.pslverr   = 1'b0;
    s_d.probe_clk = s_q.probe_arm;
    s_d.probe_arm = 1'b0;
    if (take) begin
      s_d.pready  = 1'b1;
      s_d.pslverr = ~rd_hit;
      s_d.prdata  = pwrite_i ? 32'h0000_0000 : rd_val;
      if (pwrite_i) begin
        case (paddr_i)
          ADDR_INDICATOR: s_d.ind = pwdata_i[3:0];
          ADDR_PROBE: begin
            s_d.probe     = pwdata_i[7:0];
            s_d.probe_arm = 1'b1;
          end
          ADDR_SER_STAT: begin
            if (pwdata_i[STAT_OVERRUN]) s_d.rx_overrun = 1'b0;
            if (pwdata_i[STAT_FRAMING]) s_d.rx_framing = 1'b0;
          end
          ADDR_HANDSHAKE: s_d.clear = pwdata_i[HS_CLEAR];
          ADDR_USB_PORT: begin
            s_d.usb_out  = pwdata_i[7:0];
            s_d.usb_strb = pwdata_i[USB_STRB_LSB +: 3];
          end
          ADDR_USB_DIR:   s_d.usb_oe = pwdata_i[7:0];
          default:        s_d.usb_oe = s_q.usb_oe;
        endcase
      end else if (paddr_i == ADDR_SERIAL) begin
        s_d.rx_valid = 1'b0;
      end
    end

    // transmitter: start, 8 data lsb first, stop, no parity
    if (fifo_out_valid && fifo_out_ready) begin
      s_d.tx_line  = 1'b0;
      s_d.tx_shift = {1'b1, fifo_out_data};
      s_d.tx_left  = FRAME_PERIODS;
      s_d.tx_cnt   = BIT_CNT_MAX;
    end else if (s_q.tx_left != '0) begin
      if (s_q.tx_cnt == '0) begin
        s_d.tx_cnt  = BIT_CNT_MAX;
        s_d.tx_left = s_q.tx_left - 1'b1;
        if (s_q.tx_left != 4'd1) begin
          s_d.tx_line  = s_q.tx_shift[0];
          s_d.tx_shift = {1'b1, s_q.tx_shift[8:1]};
        end
      end else begin
        s_d.tx_cnt = s_q.tx_cnt - 1'b1;
      end
    end

    // receiver samples each bit at its middle
    case (s_q.rx_state)
      RX_IDLE: begin
        if (!hs_sync[0]) begin
          s_d.rx_state = RX_START;
          s_d.rx_cnt   = HALF_CNT_MAX;
        end
      end
      RX_START: begin
        if (s_q.rx_cnt != '0) begin
          s_d.rx_cnt = s_q.rx_cnt - 1'b1;
        end else if (!hs_sync[0]) begin
          s_d.rx_state = RX_DATA;
          s_d.rx_cnt   = BIT_CNT_MAX;
          s_d.rx_bit   = '0;
        end else begin
          s_d.rx_state = RX_IDLE;  // glitch, not a start bit
        end
      end
      RX_DATA: begin
        if (s_q.rx_cnt != '0) begin
          s_d.rx_cnt = s_q.rx_cnt - 1'b1;
        end else begin
          s_d.rx_shift = {hs_sync[0], s_q.rx_shift[7:1]};
          s_d.rx_cnt   = BIT_CNT_MAX;
          s_d.rx_bit   = s_q.rx_bit + 1'b1;
          if (s_q.rx_bit == LAST_DATA_BIT) s_d.rx_state = RX_STOP;
        end
      end
      RX_STOP: begin
        if (s_q.rx_cnt != '0) begin
          s_d.rx_cnt = s_q.rx_cnt - 1'b1;
        end else begin
          s_d.rx_state = RX_IDLE;
          if (hs_sync[0]) begin
            if (s_q.rx_valid) s_d.rx_overrun = 1'b1;
            s_d.rx_data  = s_q.rx_shift;
            s_d.rx_valid = 1'b1;
          end else begin
            s_d.rx_framing = 1'b1;  // stop bit low, byte dropped
          end
        end
      end
      default: s_d.rx_state = RX_IDLE;
    endcase
  end

  // single state register
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q          <= '0;
      s_q.ind      <= IND_RST;
      s_q.probe    <= PROBE_RST;
      s_q.clear    <= CLEAR_RST;
      s_q.usb_out  <= USB_DATA_RST;
      s_q.usb_oe   <= USB_OE_RST;
      s_q.usb_strb <= USB_STRB_RST;
      s_q.tx_line  <= 1'b1;
      s_q.rx_state <= RX_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // every output straight from the state register
  assign prdata_o                = s_q.prdata;
  assign pready_o                = s_q.pready;
  assign pslverr_o               = s_q.pslverr;
  assign debug_indicator_out_o   = s_q.ind;
  assign probe_data_out_o        = s_q.probe;
  assign probe_clock_out_o       = s_q.probe_clk;
  assign serial_tx_out_o         = s_q.tx_line;
  assign bridge_clear_out_o      = s_q.clear;
  assign usb_fifo_data_o         = s_q.usb_out;
  assign usb_fifo_data_oe_o      = s_q.usb_oe;
  assign usb_fifo_read_strobe_o  = s_q.usb_strb[0];
  assign usb_fifo_write_strobe_o = s_q.usb_strb[1];
  assign usb_fifo_send_now_o     = s_q.usb_strb[2];

endmodule : dio_top
`default_nettype wire

// ===== tb/dio_checker.sv
// Purpose: port-level checks of the debug i/o block
// Assumes: sees only ports of dio_top
// Notes:   bound to dio_top below
`timescale 1ns/1ps
`default_nettype none
module dio_checker
  import dio_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        arst_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic [3:0]  debug_indicator_out_o,
  input wire logic        probe_clock_out_o,
  input wire logic        serial_tx_out_o,
  input wire logic        bridge_clear_out_o,
  input wire logic [7:0]  usb_fifo_data_o,
  input wire logic        usb_fifo_read_strobe_o,
  input wire logic        usb_fifo_write_strobe_o,
  input wire logic        usb_fifo_send_now_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  // write taken at this edge, and the probe strobe shape after it
  sequence wr_s(logic [7:0] a);
    psel_i && penable_i && !pready_o && pwrite_i && paddr_i == a;
  endsequence
  sequence pulse_s;
    !probe_clock_out_o ##1 probe_clock_out_o ##1 !probe_clock_out_o;
  endsequence

  rst_ind_a: assert property (
    $rose(arst_n_i) |-> debug_indicator_out_o == IND_RST)
    else $error("indicators wrong after reset");
  rst_usb_a: assert property ($rose(arst_n_i) |->
    usb_fifo_data_o == USB_DATA_RST && {usb_fifo_send_now_o,
    usb_fifo_write_strobe_o, usb_fifo_read_strobe_o} == USB_STRB_RST)
    else $error("usb port wrong after reset");
  rst_clear_a: assert property (
    $rose(arst_n_i) |-> !bridge_clear_out_o && serial_tx_out_o)
    else $error("clear or tx wrong after reset");
  ind_write_a: assert property (wr_s(ADDR_INDICATOR) |=>
    debug_indicator_out_o == $past(pwdata_i[3:0]))
    else $error("indicator write not applied");
  clear_write_a: assert property (wr_s(ADDR_HANDSHAKE) |=>
    bridge_clear_out_o == $past(pwdata_i[HS_CLEAR]))
    else $error("clear write not applied");
  strobe_write_a: assert property (wr_s(ADDR_USB_PORT) |=>
    {usb_fifo_send_now_o, usb_fifo_write_strobe_o,
    usb_fifo_read_strobe_o} == $past(pwdata_i[14:12]))
    else $error("usb strobes not applied");
  probe_pulse_a: assert property (wr_s(ADDR_PROBE) |=> pulse_s)
    else $error("probe clock pulse missing");
  start_bit_a: assert property (
    $fell(serial_tx_out_o) |-> ##216 !serial_tx_out_o)
    else $error("start bit too short");
  err_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
endmodule : dio_checker

bind dio_top dio_checker chk (
  .sys_clk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pwdata_i, .pready_o, .pslverr_o, .debug_indicator_out_o,
  .probe_clock_out_o, .serial_tx_out_o, .bridge_clear_out_o,
  .usb_fifo_data_o, .usb_fifo_read_strobe_o, .usb_fifo_write_strobe_o,
  .usb_fifo_send_now_o);
`default_nettype wire

// ===== tb/dio_bridge_model.sv
// Purpose: behavioural serial bridge on the far side of the block
// Assumes: 8 data bits, no parity, one stop bit, LSB first
// Notes:   send drives a frame; tx frames come out as got_o pulses
`timescale 1ns/1ps
`default_nettype none
module dio_bridge_model
  import dio_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       tx_line_i,
  output var  logic       rx_line_o,
  output var  logic       got_o,
  output var  logic [7:0] got_data_o
);
  // idle line high between frames
  initial begin
    rx_line_o = 1'b1;
    got_o = 1'b0;
    got_data_o = 8'h00;
  end

  // start low, data LSB first, stop high held as idle
  task automatic send(input logic [7:0] b, input logic stop = 1'b1);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_line_o <= f[i];
      repeat (BIT_CYCLES) @(posedge sys_clk_i);
    end
    // a low stop bit is followed by one idle bit period
    if (!stop) begin
      rx_line_o <= 1'b1;
      repeat (BIT_CYCLES) @(posedge sys_clk_i);
    end
  endtask

  // decode each transmitted frame at bit centres
  initial forever begin
    @(negedge tx_line_i);
    repeat (BIT_CYCLES / 2) @(posedge sys_clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(posedge sys_clk_i);
      got_data_o[i] <= tx_line_i;
    end
    repeat (BIT_CYCLES) @(posedge sys_clk_i);
    got_o <= tx_line_i;
    @(posedge sys_clk_i);
    got_o <= 1'b0;
  end
endmodule : dio_bridge_model
`default_nettype wire

// ===== tb/tb_debug_io_peripherals.sv
// Purpose: self-checking bench of the debug i/o block
// Assumes: APB master tasks, bridge model on the serial pins
// Notes:   reads and serial bytes are scored from queues
`timescale 1ns/1ps
`default_nettype none
module tb_debug_io_peripherals;
  import dio_pkg::*;
  logic        sys_clk_i, arst_n_i, psel_i, penable_i, pwrite_i;
  logic [7:0]  paddr_i, usb_fifo_data_i, usb_fifo_data_o;
  logic [7:0]  usb_fifo_data_oe_o, probe_data_out_o, pin_tb, got_data;
  logic [31:0] pwdata_i, prdata_o, r;
  logic        pready_o, pslverr_o, probe_clock_out_o, serial_tx_out_o;
  logic        serial_rx_in_i, bridge_request_in_i, bridge_clear_out_o;
  logic        usb_fifo_tx_space_i, usb_fifo_rx_valid_i, got;
  logic        usb_fifo_power_enable_i, usb_fifo_reset_status_i;
  logic        usb_fifo_read_strobe_o, usb_fifo_write_strobe_o;
  logic        usb_fifo_send_now_o;
  logic [2:0]  debug_button_in_i;
  logic [3:0]  debug_indicator_out_o;
  logic [32:0] rd_q[$];
  logic [7:0]  tx_q[$];
  int          err_total, n_tests, seed;

  dio_top dut (
    .sys_clk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .debug_button_in_i,
    .debug_indicator_out_o, .probe_data_out_o, .probe_clock_out_o,
    .serial_rx_in_i, .serial_tx_out_o, .bridge_request_in_i,
    .bridge_clear_out_o, .usb_fifo_data_i, .usb_fifo_data_o,
    .usb_fifo_data_oe_o, .usb_fifo_tx_space_i, .usb_fifo_rx_valid_i,
    .usb_fifo_power_enable_i, .usb_fifo_reset_status_i,
    .usb_fifo_read_strobe_o, .usb_fifo_write_strobe_o,
    .usb_fifo_send_now_o);
  dio_bridge_model br (.sys_clk_i(sys_clk_i), .tx_line_i(serial_tx_out_o),
    .rx_line_o(serial_rx_in_i), .got_o(got), .got_data_o(got_data));

  // data pins resolved from both drivers
  assign usb_fifo_data_i = (usb_fifo_data_oe_o & usb_fifo_data_o)
    | (~usb_fifo_data_oe_o & pin_tb);

  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  task automatic check(input logic [32:0] got_v, input logic [32:0] exp);
    n_tests++;
    if (got_v !== exp) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, got_v, exp);
    end
  endtask

  task automatic finish_test;
    $display("errors=%0d checks=%0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    // only the watchdog ends a wait that never sees ready
    do begin
      @(posedge sys_clk_i);
    end while (pready_o !== 1'b1);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] exp);
    rd_q.push_back(exp);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic set_pins(input logic [31:0] v);
    debug_button_in_i <= v[2:0];
    bridge_request_in_i <= v[3];
    {usb_fifo_reset_status_i, usb_fifo_power_enable_i,
      usb_fifo_rx_valid_i, usb_fifo_tx_space_i} <= v[7:4];
    pin_tb <= v[15:8];
  endtask

  // score read answers and bytes seen on the serial line
  always @(posedge sys_clk_i) begin
    if (pready_o === 1'b1 && pwrite_i === 1'b0)
      check({pslverr_o, prdata_o}, rd_q.pop_front());
    if (got === 1'b1) check(33'(got_data), 33'(tx_q.pop_front()));
  end

  initial begin
    repeat (40000) @(posedge sys_clk_i);
    err_total++;
    finish_test;
  end

  initial begin
    seed = 28013;
    arst_n_i = 1'b0;
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    set_pins(32'h7);
    repeat (20) @(posedge sys_clk_i);
    check(33'({debug_indicator_out_o, usb_fifo_data_o,
      usb_fifo_data_oe_o, usb_fifo_send_now_o, usb_fifo_write_strobe_o,
      usb_fifo_read_strobe_o, bridge_clear_out_o, serial_tx_out_o}),
      33'({IND_RST, USB_DATA_RST, USB_OE_RST, USB_STRB_RST, CLEAR_RST,
      1'b1}));
    arst_n_i <= 1'b1;
    rd(ADDR_INDICATOR, 33'(IND_RST));
    rd(ADDR_USB_PORT, 33'(USB_DATA_RST));
    rd(ADDR_HANDSHAKE, 33'h0);
    rd(ADDR_PROBE, 33'(PROBE_RST));
    // random pins and writes, each checked at the pins or read back
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      set_pins(r);
      wr(ADDR_INDICATOR, r);
      check(33'(debug_indicator_out_o), 33'(r[3:0]));
      wr(ADDR_PROBE, r >> 8);
      check(33'(probe_data_out_o), 33'(r[15:8]));
      wr(ADDR_HANDSHAKE, r >> 16);
      wr(ADDR_USB_DIR, r >> 20);
      wr(ADDR_USB_PORT, r);
      check(33'({usb_fifo_data_oe_o, usb_fifo_data_o}),
        33'({r[27:20], r[7:0]}));
      rd(ADDR_USB_DIR, 33'(r[27:20]));
      rd(ADDR_BUTTON, 33'(r[2:0]));
      rd(ADDR_HANDSHAKE, 33'({r[3], r[16]}));
      rd(ADDR_INDICATOR, 33'(r[3:0]));
      rd(ADDR_USB_PORT, 33'({r[14:12], r[7:4],
        (r[27:20] & r[7:0]) | (~r[27:20] & r[15:8])}));
    end
    rd(8'h20, 33'h1_0000_0000);
    // fill the transmit buffer until it stalls, then drain
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      tx_q.push_back(r[7:0]);
      wr(ADDR_SERIAL, r);
    end
    rd(ADDR_SER_STAT, 33'h6);
    repeat (11000) @(posedge sys_clk_i);
    rd(ADDR_SER_STAT, 33'h0);
    // receive one byte, then two to overrun
    r = $random(seed);
    br.send(r[7:0]);
    rd(ADDR_SER_STAT, 33'h1);
    rd(ADDR_SERIAL, 33'(r[7:0]));
    br.send(r[15:8]);
    br.send(r[23:16]);
    // a frame with a low stop bit is dropped and flagged
    br.send(r[31:24], 1'b0);
    rd(ADDR_SER_STAT, 33'h19);
    rd(ADDR_SERIAL, 33'(r[23:16]));
    wr(ADDR_SER_STAT, 32'h18);
    rd(ADDR_SER_STAT, 33'h0);
    repeat (4) @(posedge sys_clk_i);
    finish_test;
  end
endmodule : tb_debug_io_peripherals
`default_nettype wire
